/* File: rtl/cel_pkg.sv */
package cel_pkg;
    // mirror and nvm geometry
    localparam int          CEL_WORD_W    = 16;
    localparam int          CEL_BYTE_W    = 8;
    localparam int          CEL_NVM_AW    = 8;
    localparam int          CEL_MIR_AW    = 4;
    localparam int          CEL_ECC_W     = 6;
    localparam logic [7:0]  CEL_KEY_ADDR  = 8'h00;
    localparam logic [7:0]  CEL_KEY_VALUE = 8'hCB;
    localparam logic [7:0]  CEL_CAL_BASE  = 8'h01;
    // gain delta field widths
    localparam int          CEL_ROOM_W    = 10;
    localparam int          CEL_EVEN_W1   = 4;
    localparam int          CEL_EVEN_WX   = 2;
    localparam int          CEL_ODD_W1    = 7;
    localparam int          CEL_ODD_WX    = 6;
    localparam int          CEL_CUR_W     = 9;
    // mirror word indices of the decoded terms
    localparam logic [3:0]  CEL_IDX_ROOM  = 4'h0;
    localparam logic [3:0]  CEL_IDX_TEMP1 = 4'h1;
    localparam logic [3:0]  CEL_IDX_TEMPX = 4'h2;
    localparam logic [3:0]  CEL_IDX_CUR0  = 4'h4;
    // amplifier gain select codes: 4, 16, 64, 256
    localparam logic [1:0]  CEL_PGA_4     = 2'h0;
    localparam logic [1:0]  CEL_PGA_16    = 2'h1;
    localparam logic [1:0]  CEL_PGA_64    = 2'h2;
    localparam logic [1:0]  CEL_PGA_256   = 2'h3;
    // unity in 1.15 fixed point
    localparam logic [17:0] CEL_UNITY     = 18'h08000;
    // delta steps onto the 1.15 unity scale
    localparam int          CEL_FINE_SH   = 2; // 0.01221 percent step
    localparam int          CEL_CUR_SH    = 5; // 0.09766 percent step
    localparam int          CEL_WGT_SH    = 7 - CEL_FINE_SH; // weight 128

    typedef enum logic [7:0] {
        CEL_S_FUSE  = 8'h01,
        CEL_S_KEYRQ = 8'h02,
        CEL_S_KEYWT = 8'h04,
        CEL_S_HIRQ  = 8'h08,
        CEL_S_HIWT  = 8'h10,
        CEL_S_LORQ  = 8'h20,
        CEL_S_LOWT  = 8'h40,
        CEL_S_IDLE  = 8'h80
    } cel_state_t;
endpackage : cel_pkg

/* File: rtl/cel_mirror_ram.sv */
`timescale 1ns/1ps
`default_nettype none
// mirror memory, registered read port
module cel_mirror_ram
    import cel_pkg::*;
#(
    parameter int AW = CEL_MIR_AW,
    parameter int DW = CEL_WORD_W + CEL_ECC_W
) (
    input  wire logic          clk,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    input  wire logic [AW-1:0] rdAddr,
    output logic      [DW-1:0] rdData
);
    logic [DW-1:0] mem [2**AW];

    // write port and registered read
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule : cel_mirror_ram
`default_nettype wire

/* File: rtl/cel_calibration_eeprom_loader.sv */
// Operation
// - nvm is recognised only if byte 00 holds key CB
// - host write with direction 0 makes the block write that nvm byte
// - host write with direction 1 fetches byte, returned in read-data field
// - every reset loads mirror from fuses, then publishes mirror contents
// - recognised nvm overwrites the fuse mirror automatically at init
// - mirror words are 16 bits, built from two nvm bytes
// - word n takes nvm byte 2n+1 as high, 2n+2 as low
// - every calibration word is ecc-checked before the logic uses it
// - gain is one plus a stored two's-complement delta
// - temperature gain built from room value plus cold and hot deltas
// - current gain picked from four by amplifier gain 4,16,64,256
// - even-vs-odd room delta is 4 bits first pair, 2 bits others
// - odd cold delta is 7 bits first cell, 6 bits others
// - odd hot delta is 7 bits first cell, 6 bits others
`timescale 1ns/1ps
`default_nettype none
module cel_calibration_eeprom_loader
    import cel_pkg::*;
#(
    parameter int WORDS = 2**CEL_MIR_AW
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // fuse array read port, same clock
    output logic [CEL_MIR_AW-1:0]      fuseAddr,
    input  wire logic [21:0]           fuseData,
    // host control register
    input  wire logic                  ctrlWrite,
    input  wire logic [CEL_NVM_AW-1:0] ctrlAddr,
    input  wire logic [CEL_BYTE_W-1:0] nvm_write_byte,
    input  wire logic                  ctrlRead,
    output logic [CEL_BYTE_W-1:0]      nvm_read_byte,
    output logic                       ctrlBusy,
    // generic nvm byte port
    output logic                       nvmReq,
    output logic                       nvmWrite,
    output logic [CEL_NVM_AW-1:0]      nvmAddr,
    output logic [CEL_BYTE_W-1:0]      nvmWData,
    input  wire logic                  nvmDone,
    input  wire logic [CEL_BYTE_W-1:0] nvmRData,
    // functional side
    output logic                       initDone,
    output logic                       nvmFound,
    input  wire logic [CEL_MIR_AW-1:0] calAddr,
    output logic [CEL_WORD_W-1:0]      calWord,
    output logic                       calEccErr,
    input  wire logic [1:0]            pgaSel,
    input  wire logic signed [7:0]     tempWeight,
    output logic [17:0]                oddCellGain,
    output logic [17:0]                currentGain
);
    if (WORDS != 2**CEL_MIR_AW) begin : g_bad_words
        $error("WORDS must match mirror size");
    end

    typedef struct packed {
        cel_state_t                st;
        logic [CEL_MIR_AW-1:0]     idx;
        logic [CEL_BYTE_W-1:0]     hiByte;
        logic                      found;
        logic                      fuseGo;
        logic                      hostOp;
        logic                      req;
        logic                      wr;
        logic [CEL_NVM_AW-1:0]     addr;
        logic [CEL_BYTE_W-1:0]     wdata;
        logic [CEL_BYTE_W-1:0]     rdByte;
        logic                      done;
        logic                      memWe;
        logic [CEL_MIR_AW-1:0]     memAddr;
        logic [21:0]               memData;
    } cel_reg_t;

    cel_reg_t s_r, s_nxt;
    logic [21:0] ramRd;
    logic [CEL_WORD_W-1:0] nvmWord;

    // simple parity-style ecc: six check bits over 16 data bits
    function automatic logic [CEL_ECC_W-1:0] celEcc(
        input logic [CEL_WORD_W-1:0] d);
        logic [CEL_ECC_W-1:0] e;
        e = '0;
        for (int i = 0; i < CEL_WORD_W; i++) begin
            e[i % CEL_ECC_W] = e[i % CEL_ECC_W] ^ d[i];
        end
        return e;
    endfunction : celEcc

    assign nvmWord = {s_r.hiByte, nvmRData};

    // sequencer: fuse copy, key probe, nvm reload, host access
    always_comb begin
        s_nxt = s_r;
        s_nxt.req = 1'b0;
        s_nxt.memWe = 1'b0;
        case (s_r.st)
            CEL_S_FUSE: begin
                // fuse word arrives one cycle after its address
                // so each write lands at the previous index
                s_nxt.memWe = s_r.fuseGo;
                s_nxt.memAddr = s_r.idx - 1'b1;
                s_nxt.memData = fuseData;
                s_nxt.fuseGo = 1'b1;
                s_nxt.idx = s_r.idx + 1'b1;
                if (s_r.fuseGo && s_r.idx == '0) begin
                    s_nxt.st = CEL_S_KEYRQ;
                end
            end
            CEL_S_KEYRQ: begin
                s_nxt.req = 1'b1;
                s_nxt.wr = 1'b0;
                s_nxt.addr = CEL_KEY_ADDR;
                s_nxt.st = CEL_S_KEYWT;
            end
            CEL_S_KEYWT: begin
                if (nvmDone) begin
                    s_nxt.found = (nvmRData == CEL_KEY_VALUE);
                    s_nxt.idx = '0;
                    s_nxt.st = (nvmRData == CEL_KEY_VALUE) ?
                               CEL_S_HIRQ : CEL_S_IDLE;
                end
            end
            CEL_S_HIRQ: begin
                s_nxt.req = 1'b1;
                s_nxt.wr = 1'b0;
                s_nxt.addr = CEL_CAL_BASE + {3'h0, s_r.idx, 1'b0};
                s_nxt.st = CEL_S_HIWT;
            end
            CEL_S_HIWT: begin
                if (nvmDone) begin
                    s_nxt.hiByte = nvmRData;
                    s_nxt.st = CEL_S_LORQ;
                end
            end
            CEL_S_LORQ: begin
                s_nxt.req = 1'b1;
                s_nxt.addr = s_r.addr + 1'b1;
                s_nxt.st = CEL_S_LOWT;
            end
            CEL_S_LOWT: begin
                if (nvmDone && s_r.hostOp) begin
                    s_nxt.rdByte = s_r.wr ? s_r.rdByte : nvmRData;
                    s_nxt.hostOp = 1'b0;
                    s_nxt.st = CEL_S_IDLE;
                end else if (nvmDone) begin
                    s_nxt.memWe = 1'b1;
                    s_nxt.memAddr = s_r.idx;
                    s_nxt.memData = {celEcc(nvmWord), nvmWord};
                    s_nxt.idx = s_r.idx + 1'b1;
                    s_nxt.st = (s_r.idx == '1) ? CEL_S_IDLE : CEL_S_HIRQ;
                end
            end
            CEL_S_IDLE: begin
                s_nxt.done = 1'b1;
                // one access in flight; commands accepted only here
                if (ctrlWrite) begin
                    s_nxt.req = 1'b1;
                    s_nxt.hostOp = 1'b1;
                    s_nxt.addr = ctrlAddr;
                    s_nxt.wdata = nvm_write_byte;
                    s_nxt.st = CEL_S_LOWT;
                    s_nxt.wr = ~ctrlRead;
                end
            end
            default: begin
                s_nxt.st = CEL_S_FUSE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '{st: CEL_S_FUSE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    cel_mirror_ram #(.AW(CEL_MIR_AW), .DW(22)) u_mirror (
        .clk    (clk),
        .wrEn   (s_r.memWe),
        .wrAddr (s_r.memAddr),
        .wrData (s_r.memData),
        .rdAddr (calAddr),
        .rdData (ramRd)
    );

    // ecc check on every mirror read
    logic [CEL_WORD_W-1:0] calRaw;
    logic                  eccBad;
    assign calRaw = ramRd[CEL_WORD_W-1:0];
    assign eccBad = celEcc(calRaw) != ramRd[21:CEL_WORD_W];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            calWord   <= '0;
            calEccErr <= 1'b0;
        end else begin
            calWord   <= (eccBad || !s_r.done) ? '0 : calRaw;
            calEccErr <= eccBad && s_r.done;
        end
    end

    // gain terms, captured into shadow words after init
    logic [CEL_WORD_W-1:0] roomW, tempW, curW [4];
    logic signed [CEL_ROOM_W-1:0] odd_cell_room_gain;
    logic signed [CEL_ODD_W1-1:0] odd_cell_cold_delta, odd_cell_hot_delta;
    logic signed [CEL_EVEN_W1-1:0] even_cell_room_delta;
    logic signed [CEL_CUR_W-1:0]  gain_delta;
    logic signed [17:0] tempTerm;
    logic signed [17:0] weightWide, coldMul, hotMul;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            roomW <= '0;
            tempW <= '0;
            for (int i = 0; i < 4; i++) curW[i] <= '0;
        end else if (s_r.done) begin
            if (calAddr == CEL_IDX_ROOM) roomW <= calWord;
            if (calAddr == CEL_IDX_TEMP1) tempW <= calWord;
            for (int i = 0; i < 4; i++) begin
                if (calAddr == CEL_IDX_CUR0 + 4'(i)) curW[i] <= calWord;
            end
        end
    end

    // field widths: only the wide first-cell fields are decoded
    assign odd_cell_room_gain   = roomW[CEL_ROOM_W-1:0];
    assign even_cell_room_delta = roomW[15:12];
    assign odd_cell_cold_delta  = tempW[6:0];
    assign odd_cell_hot_delta   = tempW[13:7];
    assign gain_delta = curW[pgaSel][CEL_CUR_W-1:0];

    // delta scaled by weight, widened first: -128 is full cold
    assign weightWide = 18'(tempWeight);
    assign coldMul    = 18'(odd_cell_cold_delta) * -weightWide;
    assign hotMul     = 18'(odd_cell_hot_delta) * weightWide;
    assign tempTerm   = (tempWeight < 0) ? (coldMul >>> CEL_WGT_SH)
                                         : (hotMul >>> CEL_WGT_SH);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oddCellGain <= CEL_UNITY;
            currentGain <= CEL_UNITY;
        end else begin
            oddCellGain <= CEL_UNITY
                           + (18'(odd_cell_room_gain) <<< CEL_FINE_SH)
                           + tempTerm;
            currentGain <= CEL_UNITY
                           + (18'(gain_delta) <<< CEL_CUR_SH);
        end
    end

    assign fuseAddr      = s_r.idx;
    assign nvm_read_byte = s_r.rdByte;
    assign ctrlBusy      = s_r.st != CEL_S_IDLE;
    assign nvmReq        = s_r.req;
    assign nvmWrite      = s_r.wr;
    assign nvmAddr       = s_r.addr;
    assign nvmWData      = s_r.wdata;
    assign initDone      = s_r.done;
    assign nvmFound      = s_r.found;

    keyFound_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s_r.st == CEL_S_KEYWT && nvmDone) |=>
        (nvmFound == ($past(nvmRData) == CEL_KEY_VALUE)))
        else $error("key check wrong");
    oneAccess_a: assert property (@(posedge clk) disable iff (sys_rst)
        nvmReq |=> !nvmReq)
        else $error("overlapping nvm access");
    pairAddr_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s_r.st == CEL_S_HIRQ) |=> nvmReq && nvmAddr[0])
        else $error("high byte not at odd address");
    hostRead_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s_r.st == CEL_S_IDLE && ctrlWrite) |=> nvmWrite == !$past(ctrlRead))
        else $error("direction bit misused");
    eccGate_a: assert property (@(posedge clk) disable iff (sys_rst)
        calEccErr |-> calWord == '0)
        else $error("bad word passed");
    noInitUse_a: assert property (@(posedge clk) disable iff (sys_rst)
        !initDone |=> ##1 (calWord == '0 || initDone))
        else $error("mirror used before init");
    unityGain_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 (currentGain ==
             CEL_UNITY + (18'($past(gain_delta)) <<< CEL_CUR_SH)))
        else $error("current gain not unity plus delta");
    fuseFirst_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s_r.st == CEL_S_KEYRQ) |-> $past(s_r.st) == CEL_S_FUSE)
        else $error("nvm probed before fuse copy");
endmodule : cel_calibration_eeprom_loader
`default_nettype wire

/* File: bench/cel_nvm_model.sv */
`timescale 1ns/1ps
`default_nettype none
// byte-wide nvm with a variable answer delay
module cel_nvm_model
    import cel_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       req,
    input  wire logic       wr,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic [2:0] lat,
    output logic            done,
    output logic      [7:0] rdata
);
    logic [7:0] mem [256];
    logic [7:0] a;
    int         cnt;
    // key byte first, then a fixed pattern
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i * 29 + 3);
        mem[CEL_KEY_ADDR] = CEL_KEY_VALUE;
        done = 1'b0;
        rdata = 8'h00;
        cnt = 0;
    end
    // one access at a time; read data toggles when not valid
    always @(posedge clk) begin
        if (req) begin
            a = addr;
            if (wr) mem[addr] = wdata;
            cnt = int'(lat) + 2;
        end else if (cnt > 0) begin
            cnt--;
        end
        if (!req && cnt == 1) begin
            done <= #1 1'b1;
            rdata <= #1 mem[a];
        end else begin
            done <= #1 1'b0;
            rdata <= #1 ~rdata;
        end
    end
endmodule : cel_nvm_model
`default_nettype wire

/* File: bench/cel_calibration_eeprom_loader_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cel_calibration_eeprom_loader_test
    import cel_pkg::*;
;
    logic              clk, sys_rst, ctrlWrite, ctrlRead, nvmReq, nvmWrite;
    logic              ctrlBusy, nvmDone, initDone, nvmFound, calEccErr;
    logic        [7:0] ctrlAddr, wb, nvm_read_byte, nvmAddr, nvmWData;
    logic        [7:0] nvmRData;
    logic        [3:0] fuseAddr, calAddr;
    logic       [21:0] fuseData;
    logic       [15:0] calWord;
    logic       [17:0] oddCellGain, currentGain, e, g;
    logic        [1:0] pgaSel;
    logic        [2:0] lat, k;
    logic signed [7:0] tempWeight;
    logic        [7:0] nvmRef [256];
    logic       [17:0] expQ [$];
    logic        [2:0] kindQ [$];
    logic       [31:0] rng;
    logic              rdPend;
    int                fail_count, n_tests, cyc, tick;
    cel_calibration_eeprom_loader cel_calibration_eeprom_loader_i (
        .clk(clk), .sys_rst(sys_rst), .fuseAddr(fuseAddr),
        .fuseData(fuseData), .ctrlWrite(ctrlWrite), .ctrlAddr(ctrlAddr),
        .nvm_write_byte(wb), .ctrlRead(ctrlRead),
        .nvm_read_byte(nvm_read_byte), .ctrlBusy(ctrlBusy),
        .nvmReq(nvmReq), .nvmWrite(nvmWrite), .nvmAddr(nvmAddr),
        .nvmWData(nvmWData), .nvmDone(nvmDone), .nvmRData(nvmRData),
        .initDone(initDone), .nvmFound(nvmFound), .calAddr(calAddr),
        .calWord(calWord), .calEccErr(calEccErr), .pgaSel(pgaSel),
        .tempWeight(tempWeight), .oddCellGain(oddCellGain),
        .currentGain(currentGain));
    cel_nvm_model cel_nvm_model_i (
        .clk(clk), .req(nvmReq), .wr(nvmWrite), .addr(nvmAddr),
        .wdata(nvmWData), .lat(lat), .done(nvmDone), .rdata(nvmRData));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    // fuse word and its folded parity
    function automatic logic [15:0] fw(input logic [3:0] a);
        return {a, a, 8'h00};
    endfunction : fw
    function automatic logic [5:0] fecc(input logic [15:0] d);
        logic [5:0] p;
        p = 6'h00;
        for (int i = 0; i < 16; i++) p[i % 6] ^= d[i];
        return p;
    endfunction : fecc
    // expected gains from the nvm copy: unity plus scaled delta
    function automatic logic [17:0] gexpCur(input logic [1:0] s);
        int          i;
        logic [15:0] w;
        i = 2 * (int'(CEL_IDX_CUR0) + int'(s)) + 1;
        w = {nvmRef[i], nvmRef[i+1]};
        return CEL_UNITY + (18'($signed(w[CEL_CUR_W-1:0])) << CEL_CUR_SH);
    endfunction : gexpCur
    // full-cold weight: room delta plus the whole cold delta
    function automatic logic [17:0] gexpOdd();
        logic [15:0] r, t;
        r = {nvmRef[1], nvmRef[2]};
        t = {nvmRef[3], nvmRef[4]};
        return CEL_UNITY
               + (18'($signed(r[CEL_ROOM_W-1:0])) << CEL_FINE_SH)
               + (18'($signed(t[CEL_ODD_W1-1:0])) << CEL_FINE_SH);
    endfunction : gexpOdd
    task automatic finish_test();
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    // note an expected value; the monitor compares it later
    task automatic want(input logic [2:0] kd, input logic [3:0] a,
                        input logic [17:0] v);
        calAddr = a;
        kindQ.push_back(kd);
        expQ.push_back(v);
        tick = 4;
        repeat (4) step();
    endtask : want
    // one host command, waits until the block is idle again
    task automatic cmd(input logic rd, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        ctrlWrite = 1'b1;
        ctrlRead = rd;
        ctrlAddr = a;
        wb = d;
        step();
        ctrlWrite = 1'b0;
        if (rd) begin
            kindQ.push_back(3'h1);
            expQ.push_back(18'(nvmRef[a]));
            rdPend = 1'b1;
        end else nvmRef[a] = d;
        while (ctrlBusy !== 1'b0 && n < 100) begin
            step();
            n++;
        end
        step();
    endtask : cmd
    task automatic rst();
        int n;
        n = 0;
        sys_rst = 1'b1;
        repeat (2) step();
        sys_rst = 1'b0;
        while (initDone !== 1'b1 && n < 2000) begin
            step();
            n++;
        end
    endtask : rst
    // clock, fuse array answer, random nvm delay, run limit
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        // fuse word 14 carries a flipped data bit
        fuseData <= #1 {fecc(fw(fuseAddr)),
                        fw(fuseAddr) ^ {15'h0000, fuseAddr == 4'hE}};
        lat <= #1 3'(xs());
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    // result monitor: takes the oldest note when a result shows
    always @(negedge clk) begin
        if (tick > 0) tick--;
        if (tick == 1 || (rdPend && ctrlBusy === 1'b0)) begin
            k = kindQ.pop_front();
            e = expQ.pop_front();
            case (k)
                3'h0: g = 18'(calWord);
                3'h1: g = 18'(nvm_read_byte);
                3'h2: g = currentGain;
                3'h3: g = oddCellGain;
                3'h5: g = 18'(calEccErr);
                default: g = 18'(nvmFound);
            endcase
            n_tests++;
            if (g !== e) begin
                fail_count++;
                $display("BAD t=%0t exp=%h got=%h", $time, e, g);
            end
            rdPend = 1'b0;
        end
    end
    initial begin
        {sys_rst, ctrlWrite, ctrlRead, ctrlAddr, wb, rdPend} = '0;
        {calAddr, pgaSel, tempWeight, lat, fuseData} = '0;
        {fail_count, n_tests, cyc, tick} = '0;
        rng = 32'h5534;
        for (int i = 0; i < 256; i++) nvmRef[i] = 8'(i * 29 + 3);
        rst();
        want(3'h4, 4'h0, 18'h00001);
        for (int n = 0; n < 16; n++)
            want(3'h0, 4'(n), {2'b0, nvmRef[2*n+1], nvmRef[2*n+2]});
        // gains from the reloaded words, weight at full cold
        pgaSel = 2'(xs());
        tempWeight = 8'sh80;
        want(3'h2, 4'hF, gexpCur(pgaSel));
        want(3'h3, 4'hF, gexpOdd());
        // back-to-back host writes and reads above the gain copy
        for (int i = 0; i < 8; i++) begin
            ctrlAddr = 8'(33 + xs() % 200);
            cmd(1'b0, ctrlAddr, 8'(xs()));
            cmd(1'b1, ctrlAddr, 8'(xs()));
        end
        cmd(1'b0, CEL_KEY_ADDR, 8'h00);
        rst();
        want(3'h4, 4'h0, 18'h00000);
        for (int n = 0; n < 16; n++)
            want(3'h0, 4'(n), (n == 14) ? 18'h00000
                                        : {2'b0, fw(4'(n))});
        want(3'h5, 4'hE, 18'h00001);
        pgaSel = 2'h0;
        want(3'h2, 4'h0, CEL_UNITY);
        want(3'h3, 4'h0, CEL_UNITY);
        finish_test();
    end
endmodule : cel_calibration_eeprom_loader_test
`default_nettype wire
